// file: pp2_map.svh
/*
 * Register indices, field positions, reset values and timing counts of the
 * port 2 pin block and its register bank.
 * Assumes the byte address on the APB is four times the register index.
 */
// Functional notes
// [RULE_01] In reset, both port 2 latches go quasi-bidirectional, loaded from reset level.
// [RULE_02] Each port 2 pin has its own output type; pin behaviour follows it.
// [RULE_03] Clock output enabled with RC or external clock: pin 0 carries clock/6.
// [RULE_04] Crystal option selected: pin 0 carries the oscillator amplifier output.
// [RULE_05] When selected, pin 1 feeds oscillator and clock generator, not the port; the port read still returns pin 1.
// [RULE_06] Two-wire control reads status, writes commands; resets to 80h.
// [RULE_07] Two-wire configuration bit 5 reads zero; writing it clears timer interrupt.
// [RULE_08] Two-wire data reads received bit in bit 7; write takes bit 7 only.
// [RULE_09] Priority high register at B7h mirrors bit layout of B8h; resets 00h.
// [RULE_10] Fixed bits read as shown, ignore writes; decoded accesses take one cycle.
`ifndef PP2_MAP_SVH
`define PP2_MAP_SVH

// ===========================================================================
// Register indices
`define PP2_IDX_PTR_LO    8'h82
`define PP2_IDX_PTR_HI    8'h83
`define PP2_IDX_CDIV      8'h95
`define PP2_IDX_PORT      8'ha0
`define PP2_IDX_AUX       8'ha2
`define PP2_IDX_MODE1     8'ha4
`define PP2_IDX_MODE2     8'ha5
`define PP2_IDX_IE_A      8'ha8
`define PP2_IDX_CMPA      8'hac
`define PP2_IDX_CMPB      8'had
`define PP2_IDX_IPH0      8'hb7
`define PP2_IDX_PRI_A     8'hb8
`define PP2_IDX_TWCFG     8'hc8
`define PP2_IDX_TWCON     8'hd8
`define PP2_IDX_TWDAT     8'hd9
`define PP2_IDX_ACCU      8'he0
`define PP2_IDX_IE_B      8'he8
`define PP2_IDX_MUL       8'hf0
`define PP2_IDX_PRI_B     8'hf8

// ===========================================================================
// Write masks and fixed read values
`define PP2_AUX_WMASK     8'hf9
`define PP2_AUX_FIXED     8'h02
`define PP2_CMP_WMASK     8'h3d
`define PP2_IPH0_WMASK    8'h7f
`define PP2_PRI_A_WMASK   8'h7f
`define PP2_IE_B_WMASK    8'hbf
`define PP2_PRI_B_WMASK   8'ha7
`define PP2_TWCFG_WMASK   8'hd3
`define PP2_MODE2_WMASK   8'h03

// ===========================================================================
// Field positions
`define PP2_TWCFG_TCLR_BIT  5
`define PP2_MODE1_CLKEN_BIT 4
`define PP2_TWDAT_BIT       7

// ===========================================================================
// Reset values
`define PP2_RST_ZERO      8'h00
`define PP2_RST_AUX       8'h02
`define PP2_RST_TWSTAT    8'h80
`define PP2_RST_TWDAT     8'h80
`define PP2_RST_LATCH     2'h3

// ===========================================================================
// Timing
`define PP2_DIVCLK_DIV    6
`define PP2_BOOT_LOAD     3'b011

`endif

// file: pp2_pkg.sv
/*
 * Types shared by the port 2 pin block: oscillator choice, pin modes,
 * configuration byte, two-wire status and pin drive bundles.
 * Assumes the configuration byte comes from nonvolatile configuration memory.
 */
package pp2_pkg;

	// ===================================================================
	// Enumerations
	typedef enum logic [1:0] {
		PP2_OSC_CRYSTAL,
		PP2_OSC_RC,
		PP2_OSC_EXT
	} pp2_osc_sel_e;

	typedef enum logic [1:0] {
		PP2_PIN_QUASI,
		PP2_PIN_PUSH,
		PP2_PIN_INPUT,
		PP2_PIN_OPEN_DRAIN
	} pp2_pin_mode_e;

	// ===================================================================
	// Bundles
	typedef struct packed {
		logic         reset_level_select;
		pp2_osc_sel_e osc_sel;
	} pp2_user_config_s;

	typedef struct packed {
		logic received_bit;
		logic attention;
		logic data_ready;
		logic arb_lost;
		logic start_seen;
		logic stop_seen;
		logic master_active;
	} pp2_twowire_status_s;

	typedef struct packed {
		logic [1:0] o;
		logic [1:0] oe;
	} pp2_pin_drive_s;

endpackage : pp2_pkg

// file: pp2_sfr_bank.sv
/*
 * Port 2 pin control (oscillator pins, divided clock output) and the first
 * part of the special function register bank, reached over APB.
 * Assumes one clock, pclk, which is also the CPU clock, and a two-wire
 * engine on the same clock that supplies status and takes commands.
 */
// Chosen here: register access over APB.
`include "pp2_map.svh"

module pp2_sfr_bank #(
	parameter int unsigned CLK_DIV = `PP2_DIVCLK_DIV
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [9:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire pp2_pkg::pp2_user_config_s    user_config_byte_one,
	input  wire logic [1:0]                   port_two_pin_i,
	output pp2_pkg::pp2_pin_drive_s           port_two_pin_drv,
	input  wire logic                         osc_amp_signal,
	output logic                              osc_input_pin,
	input  wire pp2_pkg::pp2_twowire_status_s twowire_status,
	output logic [7:0]                        twowire_command,
	output logic                              twowire_command_valid,
	output logic                              clear_timer_interrupt,
	output logic                              transmit_bit
);

	// ===================================================================
	// Register storage, one byte per index in bits 7:0, except the two-bit port latch and the one-bit transmit bit
	logic [7:0] ptr_lo_q;
	logic [7:0] ptr_hi_q;
	logic [7:0] cdiv_q;
	logic [7:0] aux_q;
	logic [7:0] ie_a_q;
	logic [7:0] cmpa_q;
	logic [7:0] cmpb_q;
	logic [7:0] iph0_q;
	logic [7:0] pri_a_q;
	logic [7:0] twcfg_q;
	logic [7:0] accu_q;
	logic [7:0] ie_b_q;
	logic [7:0] mul_q;
	logic [7:0] pri_b_q;
	logic [7:0] mode1_q;
	logic [7:0] mode2_q;
	logic [7:0] twstat_q;
	logic [1:0] latch_q;
	logic       xbit_q;

	// ===================================================================
	// Synchronisers and configuration capture
	// The configuration byte is static but may settle late, so it is synchronised too
	pp2_pkg::pp2_user_config_s cfg_s1_q, cfg_q;
	logic [1:0]                pin_s1_q, pin_q;
	logic [2:0]                boot_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_s1_q <= '{1'b1, pp2_pkg::PP2_OSC_RC};
			cfg_q    <= '{1'b1, pp2_pkg::PP2_OSC_RC};
			pin_s1_q <= 2'h3;
			pin_q    <= 2'h3;
		end else begin
			cfg_s1_q <= user_config_byte_one;
			cfg_q    <= cfg_s1_q;
			pin_s1_q <= port_two_pin_i;
			pin_q    <= pin_s1_q;
		end
	end

	// Reset level is only trusted once it has crossed both flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_q <= 3'h0;
		end else begin
			boot_q <= {boot_q[1:0], 1'b1};
		end
	end

	logic       boot_load;
	logic       crystal, ext_clk, rc_osc;

	assign boot_load = (boot_q == `PP2_BOOT_LOAD);
	assign crystal   = (cfg_q.osc_sel == pp2_pkg::PP2_OSC_CRYSTAL);
	assign ext_clk   = (cfg_q.osc_sel == pp2_pkg::PP2_OSC_EXT);
	assign rc_osc    = (cfg_q.osc_sel == pp2_pkg::PP2_OSC_RC);

	// ===================================================================
	// APB decode
	// Unaligned or unmapped accesses answer with an error and change nothing
	logic [7:0] idx;
	logic [7:0] wdat;
	logic [7:0] rd_val;
	logic       hit;
	logic       wr_en;
	logic       setup;

	assign idx   = paddr[9:2];
	assign wdat  = pwdata[7:0];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && hit;

	always_comb begin
		hit    = 1'b1;
		rd_val = 8'h00;
		unique case (idx)
		`PP2_IDX_PTR_LO: rd_val = ptr_lo_q;
		`PP2_IDX_PTR_HI: rd_val = ptr_hi_q;
		`PP2_IDX_CDIV:   rd_val = cdiv_q;
		`PP2_IDX_PORT:   rd_val = {6'h00, pin_q};
		`PP2_IDX_AUX:    rd_val = aux_q;
		`PP2_IDX_MODE1:  rd_val = mode1_q;
		`PP2_IDX_MODE2:  rd_val = mode2_q;
		`PP2_IDX_IE_A:   rd_val = ie_a_q;
		`PP2_IDX_CMPA:   rd_val = cmpa_q;
		`PP2_IDX_CMPB:   rd_val = cmpb_q;
		`PP2_IDX_IPH0:   rd_val = iph0_q; // [RULE_09]
		`PP2_IDX_PRI_A:  rd_val = pri_a_q;
		`PP2_IDX_TWCFG:  rd_val = twcfg_q; // [RULE_07]
		`PP2_IDX_TWCON:  rd_val = twstat_q; // [RULE_06]
		`PP2_IDX_TWDAT:  rd_val = {twstat_q[`PP2_TWDAT_BIT], 7'h00}; // [RULE_08]
		`PP2_IDX_ACCU:   rd_val = accu_q;
		`PP2_IDX_IE_B:   rd_val = ie_b_q;
		`PP2_IDX_MUL:    rd_val = mul_q;
		`PP2_IDX_PRI_B:  rd_val = pri_b_q;
		default:        hit    = 1'b0;
		endcase
		if (paddr[1:0] != 2'b00) begin
			hit = 1'b0;
		end
	end

	// Read data is captured in the setup cycle so the access phase ends at once
	logic [7:0] rdata_q;
	logic       err_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 8'h00;
			err_q   <= 1'b0;
		end else if (setup) begin
			rdata_q <= hit ? rd_val : 8'h00;
			err_q   <= !hit;
		end
	end

	assign prdata  = {24'h000000, rdata_q};
	assign pready  = 1'b1; // [RULE_10]
	assign pslverr = err_q;

	// ===================================================================
	// Plain storage registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_lo_q <= `PP2_RST_ZERO;
			ptr_hi_q <= `PP2_RST_ZERO;
			cdiv_q   <= `PP2_RST_ZERO;
			ie_a_q   <= `PP2_RST_ZERO;
			accu_q   <= `PP2_RST_ZERO;
			mul_q    <= `PP2_RST_ZERO;
		end else if (wr_en) begin
			unique case (idx)
			`PP2_IDX_PTR_LO: ptr_lo_q <= wdat;
			`PP2_IDX_PTR_HI: ptr_hi_q <= wdat;
			`PP2_IDX_CDIV:   cdiv_q   <= wdat;
			`PP2_IDX_IE_A:   ie_a_q   <= wdat;
			`PP2_IDX_ACCU:   accu_q   <= wdat;
			`PP2_IDX_MUL:    mul_q    <= wdat;
			default:       ;
			endcase
		end
	end

	// ===================================================================
	// Registers with fixed or unimplemented bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_q  <= `PP2_RST_AUX;
			cmpa_q  <= `PP2_RST_ZERO;
			cmpb_q  <= `PP2_RST_ZERO;
			ie_b_q  <= `PP2_RST_ZERO;
			pri_b_q <= `PP2_RST_ZERO;
		end else if (wr_en) begin
			unique case (idx)
			`PP2_IDX_AUX:   aux_q   <= (wdat & `PP2_AUX_WMASK) | `PP2_AUX_FIXED; // [RULE_10]
			`PP2_IDX_CMPA:  cmpa_q  <= wdat & `PP2_CMP_WMASK; // [RULE_10]
			`PP2_IDX_CMPB:  cmpb_q  <= wdat & `PP2_CMP_WMASK; // [RULE_10]
			`PP2_IDX_IE_B:  ie_b_q  <= wdat & `PP2_IE_B_WMASK; // [RULE_10]
			`PP2_IDX_PRI_B: pri_b_q <= wdat & `PP2_PRI_B_WMASK; // [RULE_10]
			default:       ;
			endcase
		end
	end

	// Both priority bytes share one bit layout, so their two write masks hold the same value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iph0_q <= `PP2_RST_ZERO; // [RULE_09]
			pri_a_q <= `PP2_RST_ZERO;
		end else if (wr_en && idx == `PP2_IDX_IPH0) begin
			iph0_q <= wdat & `PP2_IPH0_WMASK; // [RULE_09]
		end else if (wr_en && idx == `PP2_IDX_PRI_A) begin
			pri_a_q <= wdat & `PP2_PRI_A_WMASK;
		end
	end

	// ===================================================================
	// Two-wire registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			twcfg_q               <= `PP2_RST_ZERO; // [RULE_07]
			clear_timer_interrupt <= 1'b0;
		end else begin
			clear_timer_interrupt <= 1'b0;
			if (wr_en && idx == `PP2_IDX_TWCFG) begin
				twcfg_q               <= wdat & `PP2_TWCFG_WMASK; // [RULE_07]
				clear_timer_interrupt <= wdat[`PP2_TWCFG_TCLR_BIT]; // [RULE_07]
			end
		end
	end

	// Status is resampled every cycle; commands are one-cycle pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			twstat_q              <= `PP2_RST_TWSTAT; // [RULE_06]
			twowire_command       <= 8'h00;
			twowire_command_valid <= 1'b0;
		end else begin
			twstat_q              <= {twowire_status, 1'b0}; // [RULE_06]
			twowire_command_valid <= wr_en && idx == `PP2_IDX_TWCON; // [RULE_06]
			if (wr_en && idx == `PP2_IDX_TWCON) begin
				twowire_command <= wdat; // [RULE_06]
			end
		end
	end

	// Transmit bit resets to the top bit of the data register's reset value
	localparam logic [7:0] TWDAT_RST = `PP2_RST_TWDAT;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xbit_q <= TWDAT_RST[`PP2_TWDAT_BIT]; // [RULE_08]
		end else if (wr_en && idx == `PP2_IDX_TWDAT) begin
			xbit_q <= wdat[`PP2_TWDAT_BIT]; // [RULE_08]
		end
	end

	assign transmit_bit = xbit_q;

	// ===================================================================
	// Port 2 latch and mode registers
	// A latch write made before the level load is overwritten by it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= `PP2_RST_LATCH; // [RULE_01]
		end else if (boot_load) begin
			latch_q <= {2{cfg_q.reset_level_select}}; // [RULE_01]
		end else if (wr_en && idx == `PP2_IDX_PORT) begin
			latch_q <= wdat[1:0];
		end
	end

	// Mode reset value selects quasi-bidirectional on both pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode1_q <= `PP2_RST_ZERO; // [RULE_01]
			mode2_q <= `PP2_RST_ZERO; // [RULE_01]
		end else if (wr_en && idx == `PP2_IDX_MODE1) begin
			mode1_q <= wdat;
		end else if (wr_en && idx == `PP2_IDX_MODE2) begin
			mode2_q <= wdat & `PP2_MODE2_WMASK;
		end
	end

	// ===================================================================
	// Divided clock output
	// The divider runs free, so enabling the output mid-count gives a short first phase
	localparam int unsigned HALF = CLK_DIV / 2;
	localparam int unsigned CW   = $clog2(CLK_DIV);

	logic [CW-1:0] div_cnt_q;
	logic          divclk_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= '0;
			divclk_q  <= 1'b0;
		end else begin
			if (div_cnt_q == CW'(CLK_DIV - 1)) begin
				div_cnt_q <= '0;
			end else begin
				div_cnt_q <= div_cnt_q + 1'b1;
			end
			if (div_cnt_q == CW'(HALF - 1) || div_cnt_q == CW'(CLK_DIV - 1)) begin
				divclk_q <= !divclk_q; // [RULE_03]
			end
		end
	end

	// ===================================================================
	// Pin drive
	pp2_pkg::pp2_pin_drive_s drv_d, drv_q;
	logic                    clken;

	assign clken = mode1_q[`PP2_MODE1_CLKEN_BIT];

	always_comb begin
		drv_d = '0;
		for (int i = 0; i < 2; i++) begin
			drv_d.o[i] = latch_q[i];
			unique case (pp2_pkg::pp2_pin_mode_e'({mode1_q[i], mode2_q[i]}))
			pp2_pkg::PP2_PIN_QUASI:      drv_d.oe[i] = !latch_q[i]; // [RULE_02]
			pp2_pkg::PP2_PIN_PUSH:       drv_d.oe[i] = 1'b1; // [RULE_02]
			pp2_pkg::PP2_PIN_INPUT:      drv_d.oe[i] = 1'b0; // [RULE_02]
			pp2_pkg::PP2_PIN_OPEN_DRAIN: drv_d.oe[i] = !latch_q[i]; // [RULE_02]
			endcase
		end
		if (crystal) begin
			drv_d.o[0]  = osc_amp_signal; // [RULE_04]
			drv_d.oe[0] = 1'b1;
		end else if (clken && (rc_osc || ext_clk)) begin
			drv_d.o[0]  = divclk_q; // [RULE_03]
			drv_d.oe[0] = 1'b1;
		end
		if (crystal || ext_clk) begin
			drv_d.oe[1] = 1'b0; // [RULE_05]
		end
	end

	// Released high with ones in reset, matching a quasi pin at level one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_q <= '{`PP2_RST_LATCH, 2'h0};
		end else begin
			drv_q <= drv_d;
		end
	end

	assign port_two_pin_drv = drv_q;

	// Clock path: the raw pin goes to the oscillator, never through pclk flops
	assign osc_input_pin = (crystal || ext_clk) ? port_two_pin_i[1] : 1'b0; // [RULE_05]

endmodule : pp2_sfr_bank

// file: pp2_sfr_bank_assertions.sv
/*
 * Port timing checks for the port 2 pin block and its register bank.
 * Assumes only the top module's ports, one clock and an active-low reset.
 */
module pp2_sfr_bank_assertions (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [9:0]                   paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [31:0]                  prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire pp2_pkg::pp2_user_config_s    user_config_byte_one,
	input wire logic [1:0]                   port_two_pin_i,
	input wire pp2_pkg::pp2_pin_drive_s      port_two_pin_drv,
	input wire logic                         osc_input_pin,
	input wire logic [7:0]                   twowire_command,
	input wire logic                         twowire_command_valid,
	input wire logic                         clear_timer_interrupt,
	input wire logic                         transmit_bit
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr_phase;
	logic setup_r;
	logic is_xtal;
	assign wr_phase = psel & penable & pwrite;
	assign setup_r = psel & !penable & !pwrite;
	assign is_xtal = user_config_byte_one.osc_sel == pp2_pkg::PP2_OSC_CRYSTAL;

	// =====================================================================
	// Assertions
	AST_READY: assert property (pready)
		else $error("pready low");
	AST_CMD: assert property (wr_phase && paddr == 10'h360 |=>
		twowire_command_valid && twowire_command == $past(pwdata[7:0]))
		else $error("command not passed on");
	AST_CMD_ONE: assert property (twowire_command_valid |=> !twowire_command_valid)
		else $error("command pulse too long");
	AST_TCLR: assert property (wr_phase && paddr == 10'h320 |=>
		clear_timer_interrupt == $past(pwdata[5]))
		else $error("clear pulse wrong");
	AST_XBIT: assert property (wr_phase && paddr == 10'h364 |=>
		transmit_bit == $past(pwdata[7]))
		else $error("transmit bit wrong");
	AST_DATRD: assert property (setup_r && paddr == 10'h364 |=>
		(prdata & 32'hffff_ff7f) == 32'h0)
		else $error("data read low bits set");
	AST_CFGRD: assert property (setup_r && paddr == 10'h320 |=> !prdata[5])
		else $error("config bit 5 read set");
	AST_ERR: assert property (psel && !penable && paddr[1:0] != 2'b00 |=>
		pslverr && prdata == 32'h0)
		else $error("misaligned access accepted");
	AST_XTAL: assert property (is_xtal [*5] |-> port_two_pin_drv.oe == 2'b01
		&& osc_input_pin == port_two_pin_i[1])
		else $error("crystal pins wrong");

	cover property (twowire_command_valid);
	cover property (clear_timer_interrupt);
	cover property (pslverr);
endmodule : pp2_sfr_bank_assertions

bind pp2_sfr_bank pp2_sfr_bank_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .user_config_byte_one, .port_two_pin_i,
	.port_two_pin_drv, .osc_input_pin, .twowire_command, .twowire_command_valid,
	.clear_timer_interrupt, .transmit_bit);

// file: test_pp2_sfr_bank.sv
/*
 * Self-checking bench for the port 2 pin block and its register bank.
 * Assumes APB byte address = index * 4 and status sampled every cycle.
 */
module test_pp2_sfr_bank;
	timeunit 1ns;
	timeprecision 1ns;

	logic                         pclk;
	logic                         presetn;
	logic                         psel;
	logic                         penable;
	logic                         pwrite;
	logic [9:0]                   paddr;
	logic [31:0]                  pwdata;
	logic [31:0]                  prdata;
	logic                         pready;
	logic                         pslverr;
	pp2_pkg::pp2_user_config_s    cfg;
	logic [1:0]                   port_two_pin_i;
	pp2_pkg::pp2_pin_drive_s      drv;
	logic                         osc_amp_signal;
	logic                         osc_input_pin;
	pp2_pkg::pp2_twowire_status_s st;
	logic [7:0]                   twowire_command;
	logic                         twowire_command_valid;
	logic                         clear_timer_interrupt;
	logic                         transmit_bit;
	logic [7:0]                   rd;
	logic [7:0]                   hi;
	logic [7:0]                   tr;
	logic                         prev;
	int                           miscompares;
	int                           total_checks;

	localparam logic [7:0] IDX [14] = '{8'h82, 8'h83, 8'h95, 8'ha2, 8'ha8, 8'hac, 8'had,
		8'hb7, 8'hb8, 8'hc8, 8'he0, 8'he8, 8'hf0, 8'hf8};
	localparam logic [7:0] MSK [14] = '{8'hff, 8'hff, 8'hff, 8'hfb, 8'hff, 8'h3d, 8'h3d,
		8'h7f, 8'h7f, 8'hd3, 8'hff, 8'hbf, 8'hff, 8'ha7};
	localparam logic [7:0] PIN [4] = '{8'h06, 8'h07, 8'h04, 8'h06};

	pp2_sfr_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .user_config_byte_one(cfg), .port_two_pin_i,
		.port_two_pin_drv(drv), .osc_amp_signal, .osc_input_pin, .twowire_status(st),
		.twowire_command, .twowire_command_valid, .clear_timer_interrupt, .transmit_bit);

	always #25 pclk = ~pclk;

	// =====================================================================
	// Tasks
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("BAD t=%0t seen %h want %h", $time, s, e);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d bad %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// Waits for pready under a bound; a hang ends the run
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
		input logic [1:0] lo = 2'b00);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, lo};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			finish_test();
		end
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask : cyc

	// =====================================================================
	// Sequence
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		finish_test();
	end

	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		cfg = '{1'b0, pp2_pkg::PP2_OSC_RC};
		st = 7'h40;
		port_two_pin_i = 2'b00;
		osc_amp_signal = 0;
		miscompares = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		cyc(6);
		check(8'(drv), 8'h03);
		foreach (IDX[k]) begin
			xfer(0, IDX[k], 8'h00);
			check(rd, IDX[k] == 8'ha2 ? 8'h02 : 8'h00);
		end
		xfer(0, 8'hd8, 8'h00);
		check(rd, 8'h80);
		xfer(0, 8'hd9, 8'h00);
		check(rd, 8'h80);
		foreach (IDX[k]) begin
			xfer(1, IDX[k], 8'hff);
			xfer(0, IDX[k], 8'h00);
			check(rd, MSK[k]);
		end
		$display("register map done");
		// Status changes while idle; reads must follow it
		st <= 7'h2b;
		cyc(2);
		xfer(0, 8'hd8, 8'h00);
		check(rd, 8'h56);
		xfer(0, 8'hd9, 8'h00);
		check(rd, 8'h00);
		xfer(1, 8'hd8, 8'h5a);
		#1;
		check(twowire_command, 8'h5a);
		check(8'(twowire_command_valid), 8'h01);
		cyc(1);
		check(8'(twowire_command_valid), 8'h00);
		xfer(1, 8'hc8, 8'h20);
		#1;
		check(8'(clear_timer_interrupt), 8'h01);
		xfer(0, 8'hc8, 8'h00);
		check(rd, 8'h00);
		xfer(1, 8'hd9, 8'h7f);
		#1;
		check(8'(transmit_bit), 8'h00);
		xfer(0, 8'h81, 8'h00);
		check(8'(pslverr), 8'h01);
		check(rd, 8'h00);
		// Unaligned write is refused and leaves the register as it was
		xfer(1, 8'h82, 8'h55, 2'b10);
		check(8'(pslverr), 8'h01);
		check(rd, 8'h00);
		xfer(0, 8'h82, 8'h00);
		check(rd, 8'hff);
		$display("two-wire done");
		xfer(1, 8'ha0, 8'h01);
		for (int k = 0; k < 4; k++) begin
			xfer(1, 8'ha4, {6'h0, {2{k[1]}}});
			xfer(1, 8'ha5, {6'h0, {2{k[0]}}});
			cyc(2);
			check(8'(drv), PIN[k]);
		end
		xfer(1, 8'ha5, 8'hff);
		xfer(0, 8'ha5, 8'h00);
		check(rd, 8'h03);
		// Divided clock: 12 samples hold 6 highs and 4 edges at any phase
		xfer(1, 8'ha4, 8'h10);
		cyc(3);
		hi = 0;
		tr = 0;
		prev = drv.o[0];
		repeat (12) begin
			cyc(1);
			hi += 8'(drv.o[0]);
			tr += 8'(drv.o[0] != prev);
			prev = drv.o[0];
		end
		check(hi, 8'h06);
		check(tr, 8'h04);
		check(8'(drv.oe[0]), 8'h01);
		@(posedge pclk);
		cfg <= '{1'b0, pp2_pkg::PP2_OSC_CRYSTAL};
		port_two_pin_i <= 2'b10;
		osc_amp_signal <= 1'b1;
		cyc(6);
		check(8'(drv), 8'h05);
		check(8'(osc_input_pin), 8'h01);
		xfer(0, 8'ha0, 8'h00);
		check(rd, 8'h02);
		port_two_pin_i <= 2'b00;
		osc_amp_signal <= 1'b0;
		cyc(3);
		check(8'(drv), 8'h01);
		check(8'(osc_input_pin), 8'h00);
		$display("pins done");
		@(posedge pclk);
		cfg <= '{1'b1, pp2_pkg::PP2_OSC_RC};
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		cyc(6);
		check(8'(drv), 8'h0c);
		check(8'(transmit_bit), 8'h01);
		check(twowire_command, 8'h00);
		$display("reset level done");
		finish_test();
	end
endmodule : test_pp2_sfr_bank
